// ==== dv/tb_top.sv ====
// Self-checking bench for the stop-cause and restart block
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                                      clk = 1'b0;
  logic                                      rst = 1'b1;
  vasr_pkg::vasr_wb_req_type                 wb_req = '0;
  vasr_pkg::vasr_cause_type                  cause = '0;
  logic [31:0]                               wb_dat_r;
  logic                                      wb_ack;
  logic [vasr_pkg::NAXIS-1:0]                servo_err;
  logic [7:0]                                servo_err_code;
  logic [vasr_pkg::SPW-1:0]                  virt_speed = 16'h0000;
  logic [vasr_pkg::NAXIS-1:0][vasr_pkg::SPW-1:0] axis_speed;
  logic [vasr_pkg::NAXIS-1:0]                servo_on;
  logic [vasr_pkg::NAXIS-1:0]                fault_req = '0;
  logic                                      enc_input_run;
  logic                                      virt_mode;
  logic                                      irq;
  logic [31:0]                               q;
  logic [15:0]                               s;
  int                                        mismatches = 0;
  int                                        checked = 0;
  // 50 MHz operation clock
  always #10 clk = ~clk;
  vasr_top u_vasr_top (.clk(clk), .rst(rst), .wb_req(wb_req), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .cause(cause), .servo_err(servo_err), .servo_err_code(servo_err_code), .virt_speed(virt_speed),
    .axis_speed(axis_speed), .servo_on(servo_on), .enc_input_run(enc_input_run), .virt_mode(virt_mode), .irq(irq));
  vasr_out_model u_vasr_out_model (.clk(clk), .servo_on(servo_on), .fault_req(fault_req),
    .fault_code(8'h5A), .servo_err(servo_err), .servo_err_code(servo_err_code));
  // Final verdict, also reached by an expired wb or wait_until timeout
  task automatic test_done;
    $display("Counts: checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One classic cycle; request held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    do begin @(posedge clk); n++; end while (wb_ack !== 1'b1 && n < 50);
    if (wb_ack !== 1'b1) begin mismatches++; test_done(); end
    q = wb_dat_r;
    wb_req <= '0;
    @(posedge clk);
  endtask
  // Bounded wait for a condition sampled at each edge
  task automatic wait_until(input bit sel_mode, input logic v);
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge clk);
      if (sel_mode ? (virt_mode === v) : (axis_speed === '0)) return;
    end
    mismatches++;
    test_done();
  endtask
  // Permit, servo on, cpu run, switch to virtual, start
  task automatic go_virtual;
    wb(1, vasr_pkg::ADR_CTRL, 32'h0000_0047);
    wait_until(1, 1'b1);
    wb(1, vasr_pkg::ADR_CTRL, 32'h0000_0027);
    repeat (4) @(posedge clk);
    `CHK(axis_speed[0], virt_speed)
  endtask
  // Reset values, unmapped place, smoothing setup
  task automatic t_regs;
    wb(0, vasr_pkg::ADR_CTRL, 0);
    `CHK(q[8:0], vasr_pkg::CTRL_RST)
    wb(0, vasr_pkg::ADR_SMOOTH, 0);
    `CHK(q[15:0], vasr_pkg::SMOOTH_RST)
    wb(0, 8'h40, 0);
    `CHK(q, 32'h0000_0000)
    for (int i = 0; i < 4; i++) wb(1, vasr_pkg::ADR_SMOOTH + 8'(4 * i), 32'h0000_0010);
    $display("test regs done");
  endtask
  // Stop command ramps by the smoothing step, start resumes
  task automatic t_decel;
    virt_speed <= 16'h0040;
    go_virtual();
    wb(1, vasr_pkg::ADR_CTRL, 32'h0000_000F);
    for (int n = 0; n < 20 && axis_speed[0] === 16'h0040; n++) @(posedge clk);
    s = axis_speed[0];
    @(posedge clk);
    `CHK(axis_speed[0], s - 16'h0010)
    wb(1, vasr_pkg::ADR_CTRL, 32'h0000_0027);
    repeat (4) @(posedge clk);
    `CHK(axis_speed[0], 16'h0040)
    $display("test decel done");
  endtask
  // Run permit loss records minor error 200
  task automatic t_permit;
    wb(1, vasr_pkg::ADR_CTRL, 32'h0000_0006);
    wait_until(1, 1'b0);
    wb(0, vasr_pkg::ADR_STAT, 0);
    `CHK({q[31:16], q[4]}, {vasr_pkg::MINOR_RUN, 1'b1})
    wait_until(0, 1'b0);
    go_virtual();
    $display("test permit done");
  endtask
  // Forced stop, refusal while out of sync, interrupt, recovery
  task automatic t_forced;
    wb(1, vasr_pkg::ADR_IMASK, 32'h0000_0002);
    cause.forced <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({servo_on, axis_speed, enc_input_run}, 69'h0)
    repeat (3) @(posedge clk);
    wb(0, vasr_pkg::ADR_STAT, 0);
    `CHK({q[9:8], q[5], q[2]}, 4'hD)
    `CHK(irq, 1'b1)
    wb(1, vasr_pkg::ADR_IMASK, 0);
    `CHK(irq, 1'b0)
    cause.forced <= 1'b0;
    wb(1, vasr_pkg::ADR_CTRL, 32'h0000_0047);
    repeat (3) @(posedge clk);
    `CHK(virt_mode, 1'b0)
    wb(1, vasr_pkg::ADR_CTRL, 32'h0000_0087);
    wb(1, vasr_pkg::ADR_STAT, 32'h0000_0004);
    go_virtual();
    $display("test forced done");
  endtask
  // One faulted axis is cut, the rest keep following
  task automatic t_servo;
    fault_req <= 4'h2;
    @(posedge clk);
    fault_req <= 4'h0;
    repeat (3) @(posedge clk);
    `CHK({servo_on[1], axis_speed[1]}, 17'h0)
    `CHK({servo_on[0], axis_speed[0]}, {1'b1, virt_speed})
    wb(0, vasr_pkg::ADR_SERR, 0);
    `CHK({q[15:8], q[3:0]}, 12'h5A2)
    wb(1, vasr_pkg::ADR_SERR, 32'h0000_000F);
    wb(0, vasr_pkg::ADR_SERR, 0);
    `CHK(q[3:0], 4'h2)
    virt_speed <= 16'h0000;
    wait_until(0, 1'b0);
    wb(1, vasr_pkg::ADR_SERR, 32'h0000_000F);
    wb(0, vasr_pkg::ADR_SERR, 0);
    `CHK(q[3:0], 4'h0)
    wb(1, vasr_pkg::ADR_CTRL, 32'h0000_0087);
    wb(1, vasr_pkg::ADR_STAT, 32'h0000_0004);
    go_virtual();
    $display("test servo done");
  endtask
  // CPU stop records minor error; watchdog cuts all axes and sets its flag
  task automatic t_cpu;
    wb(1, vasr_pkg::ADR_CTRL, 32'h0000_0003);
    wait_until(1, 1'b0);
    wb(0, vasr_pkg::ADR_STAT, 0);
    `CHK({q[31:16], q[4]}, {vasr_pkg::MINOR_RUN, 1'b1})
    cause.wdt <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({servo_on, axis_speed}, 68'h0)
    cause.wdt <= 1'b0;
    wb(0, vasr_pkg::ADR_STAT, 0);
    `CHK(q[3], 1'b1)
    $display("test cpu done");
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_decel();
    t_permit();
    t_forced();
    t_servo();
    t_cpu();
    test_done();
  end
endmodule
`default_nettype wire

// ==== dv/vasr_out_model.sv ====
// Behavioural output modules that trip a servo fault when the bench asks
`default_nettype none
module vasr_out_model (
  input  wire logic [7:0]                  fault_code,
  input  wire logic                        clk,
  input  wire logic [vasr_pkg::NAXIS-1:0]  servo_on,
  input  wire logic [vasr_pkg::NAXIS-1:0]  fault_req,
  output logic [vasr_pkg::NAXIS-1:0]       servo_err,
  output logic [7:0]                       servo_err_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_code_r;  // Last code shown, inverted outside a fault
  // Quiet lines at time zero
  initial begin
    servo_err = '0;
    servo_err_code = 8'h00;
    last_code_r = 8'h00;
  end
  // Only an energised amplifier can trip; the code is valid in the fault cycle only
  always @(posedge clk) begin
    servo_err <= fault_req & servo_on;
    if (|(fault_req & servo_on)) begin
      servo_err_code <= fault_code;
      last_code_r <= fault_code;
    end else begin
      servo_err_code <= ~last_code_r;  // Stale code would hide a missed capture
    end
  end
endmodule
`default_nettype wire

// ==== logic/vasr_axis.sv ====
// One output module: follows the virtual axis, ramps down or cuts off on stop
`default_nettype none
module vasr_axis (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire vasr_pkg::vasr_axis_cmd_type cmd,
  input  wire logic [vasr_pkg::SPW-1:0]   vin,
  input  wire logic [vasr_pkg::SPW-1:0]   step,
  output logic [vasr_pkg::SPW-1:0]        speed,
  output logic                            servo_on,
  output logic                            at_rest
);
  vasr_pkg::vasr_axis_state_type s;     // Registered state
  vasr_pkg::vasr_axis_state_type n;     // Next state

  // Stop priority: immediate cut, then follow, else smoothing ramp
  always_comb begin
    n = s;
    if (cmd.stop_imm) begin
      n.speed = '0;                     // [R8] [R10]
      n.son   = 1'b0;
    end else if (cmd.follow) begin
      n.speed = vin;
      // A servo-off command keeps the amplifier on until the ramp has ended
      n.son   = cmd.hold_off ? s.son : cmd.servo_en;  // [R3]
    end else begin
      // Clamp at zero so a large step cannot wrap the speed
      n.speed = (s.speed > step) ? s.speed - step : '0;  // [R1]
      // Servo drops in the cycle the ramp reaches rest, never earlier
      n.son   = cmd.hold_off ? (s.son & (s.speed > step)) : cmd.servo_en;  // [R3]
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign speed    = s.speed;
  assign servo_on = s.son;
  assign at_rest  = (s.speed == '0);

  a_decel_ramp: assert property (@(posedge clk) disable iff (rst) // [R1]
    (!cmd.stop_imm && !cmd.follow && speed > step) |=> speed == $past(speed) - $past(step))
    else $error("ramp step not applied");
  a_imm_cut: assert property (@(posedge clk) disable iff (rst) // [R8]
    cmd.stop_imm |=> (speed == '0) && !servo_on)
    else $error("immediate stop did not cut axis");
  a_hold_ramp: assert property (@(posedge clk) disable iff (rst) // [R3]
    (cmd.hold_off && !cmd.stop_imm && speed > step) |=> servo_on == $past(servo_on))
    else $error("servo dropped before ramp end");
endmodule
`default_nettype wire

// ==== logic/vasr_irq.sv ====
// Sticky event status, mask and one level interrupt
`default_nettype none
module vasr_irq (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [vasr_pkg::NEV-1:0]  ev,
  input  wire logic                      wr_stat,
  input  wire logic                      wr_mask,
  input  wire logic [vasr_pkg::NEV-1:0]  wdata,
  output logic [vasr_pkg::NEV-1:0]       stat,
  output logic [vasr_pkg::NEV-1:0]       mask,
  output logic                           irq
);
  vasr_pkg::vasr_irq_state_type s;      // Registered state
  vasr_pkg::vasr_irq_state_type n;      // Next state

  // Clear first, then set, so an event in the clear cycle survives
  always_comb begin
    n = s;
    if (wr_stat) begin
      n.stat = s.stat & ~wdata;
    end
    n.stat = n.stat | ev;
    if (wr_mask) begin
      n.mask = wdata;
    end
    n.irq = |(n.stat & n.mask);
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign stat = s.stat;
  assign mask = s.mask;
  assign irq  = s.irq;
endmodule
`default_nettype wire

// ==== logic/vasr_pkg.sv ====
// Shared constants and types for the virtual-axis stop and recovery block
`default_nettype none
package vasr_pkg;
  localparam int NAXIS = 4;             // Output modules served
  localparam int SPW   = 16;            // Speed word width
  localparam int NEV   = 8;             // Interrupt event count
  localparam int CTW   = 9;             // Control register width

  // Register byte offsets
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STAT   = 8'h04;
  localparam logic [7:0] ADR_ISTAT  = 8'h08;
  localparam logic [7:0] ADR_IMASK  = 8'h0C;
  localparam logic [7:0] ADR_SERR   = 8'h10;
  localparam logic [7:0] ADR_SMOOTH = 8'h20;

  // Control bits
  localparam int CTRL_PERMIT   = 0;
  localparam int CTRL_SERVO_ON = 1;
  localparam int CTRL_CPU_RUN  = 2;
  localparam int CTRL_STOP     = 3;
  localparam int CTRL_RAPID    = 4;
  localparam int CTRL_START    = 5;
  localparam int CTRL_R2V      = 6;
  localparam int CTRL_REALIGN  = 7;
  localparam int CTRL_V2R      = 8;
  localparam int STAT_SYNC     = 2;     // Sync mismatch bit, write one to clear

  localparam logic [CTW-1:0] CTRL_RST   = 9'h000;
  localparam logic [SPW-1:0] SMOOTH_RST = 16'h0001;
  localparam logic [15:0]    MINOR_RUN  = 16'h00C8;  // Minor error 200

  typedef enum logic [1:0] {VASR_REAL, VASR_VIRT, VASR_RET} vasr_mode_type;
  typedef enum logic [1:0] {VASR_NONE, VASR_DECEL, VASR_RAPID, VASR_IMMED} vasr_act_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } vasr_wb_req_type;

  typedef struct packed {
    logic forced;
    logic wdt;
    logic sys_reset;
    logic power_loss;
    logic other_err;
    logic enc_err;
  } vasr_cause_type;

  typedef struct packed {
    logic follow;
    logic stop_imm;
    logic hold_off;
    logic servo_en;
  } vasr_axis_cmd_type;

  typedef struct packed {
    logic [SPW-1:0] speed;
    logic           son;
  } vasr_axis_state_type;

  typedef struct packed {
    logic [NEV-1:0] stat;
    logic [NEV-1:0] mask;
    logic           irq;
  } vasr_irq_state_type;

  typedef struct packed {
    vasr_mode_type             mode;
    vasr_act_type              act;
    logic                      virt;
    logic [CTW-1:0]            ctrl;
    logic                      run;
    logic                      enc_run;
    logic                      sync_mm;
    logic                      realign_need;
    logic                      wdt_flag;
    logic                      minor_err;
    logic                      other_err;
    logic [NAXIS-1:0]          serr;
    logic [7:0]                serr_code;
    logic [NAXIS-1:0][SPW-1:0] smooth;
    logic                      ack;
    logic [31:0]               rdata;
  } vasr_top_state_type;
endpackage
`default_nettype wire

// ==== logic/vasr_top.sv ====
// Stop-cause handling and restart control for virtual-axis synchronous motion
// What this block does
// R1: Deceleration stop ramps outputs by smoothing constant
// R2: Stopped axis resumes on stop off plus start
// R3: Servo-off stop holds outputs off after ramp
// R4: Encoder inputs resume only after real-virtual cycle
// R5: Run permit loss records minor error 200
// R6: CPU stop records minor error 200
// R7: Forced stop: immediate servo-off, continuation forbidden
// R8: Servo error stops only that axis immediately
// R9: Servo error reset in real mode first
// R10: Watchdog, reset, power loss: immediate servo-off
// R11: Immediate stop blocks operation until re-aligned
// R12: Other errors decelerate, resume once cleared
// R13: Encoder error decelerates, needs real-mode re-align
// R14: Out-of-sync stop sets mismatch warning flag
// R15: Encoder axes take immediate input stop
// R16: Most severe stop action wins
//
// Local design decisions: the Wishbone slave port and the address map.
`default_nettype none
module vasr_top (
  input  wire logic                                      clk,
  input  wire logic                                      rst,
  input  wire vasr_pkg::vasr_wb_req_type                 wb_req,
  output logic [31:0]                                    wb_dat_r,
  output logic                                           wb_ack,
  input  wire vasr_pkg::vasr_cause_type                  cause,
  input  wire logic [vasr_pkg::NAXIS-1:0]                servo_err,
  input  wire logic [7:0]                                servo_err_code,
  input  wire logic [vasr_pkg::SPW-1:0]                  virt_speed,
  output logic [vasr_pkg::NAXIS-1:0][vasr_pkg::SPW-1:0]  axis_speed,
  output logic [vasr_pkg::NAXIS-1:0]                     servo_on,
  output logic                                           enc_input_run,
  output logic                                           virt_mode,
  output logic                                           irq
);
  vasr_pkg::vasr_top_state_type s;                    // Registered state
  vasr_pkg::vasr_top_state_type n;                    // Next state
  vasr_pkg::vasr_axis_cmd_type [vasr_pkg::NAXIS-1:0] acmd;  // Per-axis commands
  logic [vasr_pkg::NAXIS-1:0] rest;                   // Axis at zero speed
  logic [vasr_pkg::NEV-1:0]   ev;                     // Interrupt events
  logic [vasr_pkg::NEV-1:0]   istat;                  // Sticky status
  logic [vasr_pkg::NEV-1:0]   imask;                  // Interrupt mask
  logic [31:0]                bm;                     // Byte-lane mask
  logic [31:0]                wd;                     // Lane-masked write data
  logic                       acc;                    // Bus access this cycle
  logic                       wr;                     // Bus write this cycle
  logic                       imm_all;                // All-axes immediate cause
  logic                       in_virt;                // Virtual or returning
  logic                       permit_lost;            // Run permit dropped
  logic                       cpu_lost;               // Controller CPU stopped
  logic                       srv_off;                // All-axes servo-off command
  logic                       any_serr;               // Some output in servo error
  logic                       stop_run;               // Cause that halts the axis
  logic                       wr_istat;               // Write to event status
  logic                       wr_imask;               // Write to event mask

  assign imm_all     = cause.forced | cause.wdt | cause.sys_reset | cause.power_loss;
  assign in_virt     = (s.mode != vasr_pkg::VASR_REAL);
  assign permit_lost = (s.mode == vasr_pkg::VASR_VIRT) & ~s.ctrl[vasr_pkg::CTRL_PERMIT];
  assign cpu_lost    = (s.mode == vasr_pkg::VASR_VIRT) & ~s.ctrl[vasr_pkg::CTRL_CPU_RUN];
  assign srv_off     = in_virt & ~s.ctrl[vasr_pkg::CTRL_SERVO_ON];
  assign any_serr    = |servo_err;
  assign acc         = wb_req.cyc & wb_req.stb & ~s.ack;
  assign wr          = acc & wb_req.we;
  assign wr_istat    = wr & (wb_req.adr == vasr_pkg::ADR_ISTAT);
  assign wr_imask    = wr & (wb_req.adr == vasr_pkg::ADR_IMASK);
  assign stop_run    = imm_all | permit_lost | cpu_lost | srv_off | cause.other_err | cause.enc_err
                     | s.ctrl[vasr_pkg::CTRL_STOP] | s.ctrl[vasr_pkg::CTRL_RAPID];

  // Byte lanes: unselected lanes neither write nor clear, except that an event mask write loads zeros into them
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bm[i*8 +: 8] = {8{wb_req.sel[i]}};
    end
    wd = wb_req.dat & bm;
  end

  // Per-axis commands; a faulted axis is cut alone, the rest keep following
  always_comb begin
    for (int i = 0; i < vasr_pkg::NAXIS; i++) begin
      acmd[i].follow   = s.run & in_virt;                              // [R8]
      acmd[i].stop_imm = imm_all | s.serr[i] | servo_err[i];           // [R8] [R10] [R7]
      acmd[i].hold_off = ~s.ctrl[vasr_pkg::CTRL_SERVO_ON];             // [R3]
      acmd[i].servo_en = s.ctrl[vasr_pkg::CTRL_SERVO_ON] & ~s.serr[i] & ~servo_err[i] & ~imm_all;
    end
  end

  // Control, mode sequencing and register access
  always_comb begin
    n = s;
    // Pulse bits clear themselves
    n.ctrl[vasr_pkg::CTRL_START]   = 1'b0;
    n.ctrl[vasr_pkg::CTRL_R2V]     = 1'b0;
    n.ctrl[vasr_pkg::CTRL_REALIGN] = 1'b0;
    n.ctrl[vasr_pkg::CTRL_V2R]     = 1'b0;
    n.ack       = acc;
    n.rdata     = 32'h0000_0000;
    n.other_err = cause.other_err;                    // [R12]

    // Writes; set terms below are applied after, so they win
    if (wr) begin
      if (wb_req.adr == vasr_pkg::ADR_CTRL) begin
        n.ctrl = (s.ctrl & ~bm[vasr_pkg::CTW-1:0]) | wd[vasr_pkg::CTW-1:0];
      end
      if (wb_req.adr == vasr_pkg::ADR_STAT && wd[vasr_pkg::STAT_SYNC]) begin
        n.sync_mm = 1'b0;                             // [R14]
      end
      // Servo errors are reset only in real mode
      if (wb_req.adr == vasr_pkg::ADR_SERR && s.mode == vasr_pkg::VASR_REAL) begin
        n.serr = s.serr & ~wd[vasr_pkg::NAXIS-1:0];   // [R9]
      end
      for (int i = 0; i < vasr_pkg::NAXIS; i++) begin
        if (wb_req.adr == vasr_pkg::ADR_SMOOTH + 8'(4 * i)) begin
          n.smooth[i] = (s.smooth[i] & ~bm[vasr_pkg::SPW-1:0]) | wd[vasr_pkg::SPW-1:0];
        end
      end
    end

    // Most severe active cause sets the action
    if (imm_all) begin
      n.act = vasr_pkg::VASR_IMMED;                   // [R16]
    end else if (s.ctrl[vasr_pkg::CTRL_RAPID] | any_serr) begin
      n.act = vasr_pkg::VASR_RAPID;                   // [R16]
    end else if (stop_run) begin
      n.act = vasr_pkg::VASR_DECEL;                   // [R16] [R1]
    end else begin
      n.act = vasr_pkg::VASR_NONE;
    end

    // Axis run flag: any halting cause stops it, start resumes it
    if (stop_run) begin
      n.run = 1'b0;                                   // [R12] [R13]
    end else if (s.ctrl[vasr_pkg::CTRL_START] && s.mode == vasr_pkg::VASR_VIRT && !any_serr
                 && s.serr == '0 && !s.sync_mm && !s.realign_need) begin
      n.run = 1'b1;                                   // [R2]
    end

    // Latched error flags
    if (permit_lost) begin
      n.minor_err = 1'b1;                             // [R5]
    end
    if (cpu_lost) begin
      n.minor_err = 1'b1;                             // [R6]
    end
    if (cause.wdt) begin
      n.wdt_flag = 1'b1;                              // [R10]
    end
    if (any_serr) begin
      n.serr      = n.serr | servo_err;               // [R8]
      n.serr_code = servo_err_code;
    end
    if ((imm_all | any_serr) & in_virt) begin
      n.sync_mm = 1'b1;                               // [R14] [R7]
    end
    // Immediate stops and encoder faults force a real-mode re-align
    if (imm_all | any_serr | cause.enc_err) begin
      n.realign_need = 1'b1;                          // [R11] [R13]
    end else if (s.mode == vasr_pkg::VASR_REAL && s.ctrl[vasr_pkg::CTRL_REALIGN]) begin
      n.realign_need = 1'b0;
    end
    // Encoder inputs stop at once on every stop cause except other errors and the stop and rapid-stop control bits
    if (imm_all | any_serr | permit_lost | cpu_lost | srv_off | cause.enc_err) begin
      n.enc_run = 1'b0;                               // [R15]
    end

    // Mode sequencing
    case (s.mode)
      vasr_pkg::VASR_REAL: begin
        // A fault in the request cycle itself keeps the switch refused,
        // since the re-align flag it sets is not yet registered
        if (s.ctrl[vasr_pkg::CTRL_R2V] && s.ctrl[vasr_pkg::CTRL_PERMIT] && s.ctrl[vasr_pkg::CTRL_CPU_RUN]
            && !s.realign_need && !s.sync_mm && s.serr == '0 && !imm_all && !any_serr
            && !cause.enc_err) begin
          n.mode      = vasr_pkg::VASR_VIRT;          // [R5] [R6] [R7] [R10] [R11]
          n.enc_run   = 1'b1;                         // [R4]
          n.minor_err = 1'b0;
        end
      end
      vasr_pkg::VASR_VIRT: begin
        if (imm_all | any_serr | permit_lost | cpu_lost | cause.enc_err | s.ctrl[vasr_pkg::CTRL_V2R]) begin
          n.mode = vasr_pkg::VASR_RET;                // [R13]
        end
      end
      vasr_pkg::VASR_RET: begin
        // Healthy axes keep following until the virtual axis is at rest
        if (virt_speed == '0) begin
          n.run = 1'b0;
        end
        if (!s.run && (&rest)) begin
          n.mode = vasr_pkg::VASR_REAL;
        end
      end
      default: begin
        n.mode = vasr_pkg::VASR_REAL;
      end
    endcase
    n.virt = (n.mode == vasr_pkg::VASR_VIRT);

    // Read data
    if (acc && !wb_req.we) begin
      case (wb_req.adr)
        vasr_pkg::ADR_CTRL:  n.rdata = 32'(s.ctrl);
        vasr_pkg::ADR_STAT:  n.rdata = {(s.minor_err ? vasr_pkg::MINOR_RUN : 16'h0000), 6'h00, s.act,
                                        s.other_err, s.enc_run, ~(s.realign_need | s.sync_mm),
                                        s.minor_err, s.wdt_flag, s.sync_mm, s.run, s.virt};
        vasr_pkg::ADR_ISTAT: n.rdata = 32'(istat);
        vasr_pkg::ADR_IMASK: n.rdata = 32'(imask);
        vasr_pkg::ADR_SERR:  n.rdata = {16'h0000, s.serr_code, 8'(s.serr)};
        default: begin
          for (int i = 0; i < vasr_pkg::NAXIS; i++) begin
            if (wb_req.adr == vasr_pkg::ADR_SMOOTH + 8'(4 * i)) begin
              n.rdata = 32'(s.smooth[i]);
            end
          end
        end
      endcase
    end
  end

  // Events for the interrupt status, each a single-cycle pulse
  always_comb begin
    ev[0] = s.run & stop_run;
    ev[1] = in_virt & imm_all & ~s.sync_mm;
    ev[2] = n.minor_err & ~s.minor_err;
    ev[3] = |(n.serr & ~s.serr);
    ev[4] = n.sync_mm & ~s.sync_mm;
    ev[5] = cause.enc_err & s.enc_run;
    ev[6] = cause.other_err & ~s.other_err;
    ev[7] = (n.mode != s.mode);
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s        <= '0;
      s.ctrl   <= vasr_pkg::CTRL_RST;
      s.smooth <= {vasr_pkg::NAXIS{vasr_pkg::SMOOTH_RST}};
    end else begin
      s <= n;
    end
  end

  // One ramp per output module
  for (genvar g = 0; g < vasr_pkg::NAXIS; g++) begin : g_axis
    vasr_axis u_axis (
      .clk      (clk),
      .rst      (rst),
      .cmd      (acmd[g]),
      .vin      (virt_speed),
      .step     (s.smooth[g]),
      .speed    (axis_speed[g]),
      .servo_on (servo_on[g]),
      .at_rest  (rest[g])
    );
  end

  vasr_irq u_irq (
    .clk     (clk),
    .rst     (rst),
    .ev      (ev),
    .wr_stat (wr_istat),
    .wr_mask (wr_imask),
    .wdata   (wd[vasr_pkg::NEV-1:0]),
    .stat    (istat),
    .mask    (imask),
    .irq     (irq)
  );

  assign wb_ack        = s.ack;
  assign wb_dat_r      = s.rdata;
  assign enc_input_run = s.enc_run;
  assign virt_mode     = s.virt;

  a_imm_servo_off: assert property (@(posedge clk) disable iff (rst) // [R10]
    imm_all |=> servo_on == '0 && axis_speed == '0)
    else $error("immediate cause left a servo on");
  a_forced_sync: assert property (@(posedge clk) disable iff (rst) // [R7]
    (cause.forced && s.mode == vasr_pkg::VASR_VIRT) |=> s.sync_mm && s.realign_need)
    else $error("forced stop did not flag mismatch");
  a_permit_err: assert property (@(posedge clk) disable iff (rst) // [R5]
    permit_lost |=> s.minor_err ##1 !s.virt)
    else $error("permit loss not recorded");
  a_cpu_err: assert property (@(posedge clk) disable iff (rst) // [R6]
    cpu_lost |=> s.minor_err && s.mode == vasr_pkg::VASR_RET)
    else $error("cpu stop not recorded");
  a_realign_block: assert property (@(posedge clk) disable iff (rst) // [R11]
    (s.realign_need && s.mode == vasr_pkg::VASR_REAL) |=> !s.virt)
    else $error("virtual entered without re-align");
  a_enc_resume: assert property (@(posedge clk) disable iff (rst) // [R4]
    $rose(s.enc_run) |-> $past(s.mode) == vasr_pkg::VASR_REAL)
    else $error("encoder resumed outside mode switch");
  a_enc_stop: assert property (@(posedge clk) disable iff (rst) // [R15]
    (srv_off || cause.enc_err) |=> !enc_input_run)
    else $error("encoder input not stopped");
  a_severity: assert property (@(posedge clk) disable iff (rst) // [R16]
    (imm_all && s.ctrl[vasr_pkg::CTRL_RAPID]) |=> s.act == vasr_pkg::VASR_IMMED)
    else $error("immediate stop lost priority");
  a_sync_set_wins: assert property (@(posedge clk) disable iff (rst) // [R14]
    (any_serr && in_virt) |=> s.sync_mm)
    else $error("mismatch flag not set");
  a_wdt_flag: assert property (@(posedge clk) disable iff (rst) // [R10]
    cause.wdt |=> s.wdt_flag)
    else $error("watchdog flag not set");
  a_enc_refuse: assert property (@(posedge clk) disable iff (rst) // [R13]
    (cause.enc_err && s.mode == vasr_pkg::VASR_REAL) |=> !s.virt)
    else $error("virtual entered during encoder fault");
endmodule
`default_nettype wire
